// ==== rtl/spp_serial_packetizer.sv ====
// Serial port settings, host receive path, packetizer and service-port forwarding
`timescale 1ns/1ps
// Operation
// - Codes 1 to A select fixed rates
// - Above A means literal rate, nearest stored
// - Literal rates accepted from 5B9 to 5B8D80
// - Parity none, even or odd
// - One or two stop bits
// - Send packet after idle character times
// - Full packet sends without waiting
// - Zero gap forwards each character
// - 100 us silence always sends
// - Deassert CTS at hold-off byte count
// - Mode transparent, framed or escaped framed
// - Frame format for service-port data
// - Forward service-port data out serial port
module spp_serial_packetizer #(
  parameter int SILENCE_CYC = spp_pkg::SILENCE_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic rxPin,
  output logic txPin,
  output logic ctsN,
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire spp_pkg::spp_sel_t cfgSel,
  input wire logic [31:0] cfgWData,
  output logic [31:0] cfgRData,
  output spp_pkg::spp_cfg_t cfg,
  output logic pktValid,
  input wire logic pktReady,
  output spp_pkg::spp_pkt_t pkt,
  input wire logic netValid,
  output logic netReady,
  input wire spp_pkg::spp_net_t net
);

  // ****************************************
  // Settings
  // ****************************************
  localparam logic [31:0] SIL = 32'(SILENCE_CYC);
  wire [31:0] wd = cfgWData;
  wire isCode = wd >= spp_pkg::RATE_CODE_MIN && wd <= spp_pkg::RATE_CODE_MAX;
  wire isLit = wd >= spp_pkg::RATE_LIT_MIN && wd <= spp_pkg::RATE_LIT_MAX;
  wire [31:0] litDiv = spp_pkg::rate_div(wd);
  wire [31:0] codeDiv = spp_pkg::rate_div(spp_pkg::code_rate(wd[3:0]));
  wire [31:0] litRate = spp_pkg::CLK_HZ / litDiv;
  wire wrSel = cfgWrite;
  logic ovfFlag;
  logic parErrFlag;
  logic frmErrFlag;
  logic [spp_pkg::LVL_W-1:0] level;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cfg.rate <= spp_pkg::RATE_RST;
      cfg.div <= spp_pkg::DIV_W'(spp_pkg::rate_div(spp_pkg::code_rate(4'h3)));
      cfg.parity <= spp_pkg::PAR_NONE;
      cfg.stop <= 1'b0;
      cfg.gap <= spp_pkg::GAP_RST;
      cfg.hold <= spp_pkg::HOLD_RST;
      cfg.mode <= spp_pkg::MODE_TRANSPARENT;
      cfg.format <= spp_pkg::FMT_RST;
      cfg.port <= spp_pkg::PORT_RST;
    end else if (wrSel) begin
      case (cfgSel)
        spp_pkg::SEL_RATE: begin
          if (isCode) begin
            cfg.rate <= wd;
            cfg.div <= spp_pkg::DIV_W'(codeDiv);
          end else if (isLit) begin
            cfg.rate <= litRate;
            cfg.div <= spp_pkg::DIV_W'(litDiv);
          end
        end
        spp_pkg::SEL_PARITY: if (wd <= 32'(spp_pkg::PAR_ODD)) cfg.parity <= wd[1:0];
        spp_pkg::SEL_STOP: if (wd <= 32'h1) cfg.stop <= wd[0];
        spp_pkg::SEL_GAP: if (wd <= 32'hff) cfg.gap <= wd[7:0];
        spp_pkg::SEL_HOLD: begin
          if (wd >= 32'(spp_pkg::HOLD_MIN) && wd <= 32'(spp_pkg::HOLD_MAX)) begin
            cfg.hold <= wd[11:0];
          end
        end
        spp_pkg::SEL_MODE: if (wd <= 32'(spp_pkg::MODE_ESCAPED)) cfg.mode <= wd[1:0];
        spp_pkg::SEL_FORMAT: if (wd <= 32'(spp_pkg::FMT_MAX)) cfg.format <= wd[1:0];
        spp_pkg::SEL_PORT: if (wd <= 32'hffff) cfg.port <= wd[15:0];
        default: ;
      endcase
    end
  end

  wire [31:0] statusWord = {21'h0, level, frmErrFlag, parErrFlag, ovfFlag, 2'h0};
  logic [31:0] rdMux;
  always_comb begin
    case (cfgSel)
      spp_pkg::SEL_RATE: rdMux = cfg.rate;
      spp_pkg::SEL_PARITY: rdMux = {30'h0, cfg.parity};
      spp_pkg::SEL_STOP: rdMux = {31'h0, cfg.stop};
      spp_pkg::SEL_GAP: rdMux = {24'h0, cfg.gap};
      spp_pkg::SEL_HOLD: rdMux = {20'h0, cfg.hold};
      spp_pkg::SEL_MODE: rdMux = {30'h0, cfg.mode};
      spp_pkg::SEL_FORMAT: rdMux = {30'h0, cfg.format};
      spp_pkg::SEL_PORT: rdMux = {16'h0, cfg.port};
      spp_pkg::SEL_STATUS: rdMux = statusWord;
      default: rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cfgRData <= 32'h0;
    end else if (cfgRead) begin
      cfgRData <= rdMux;
    end
  end

  // ****************************************
  // Receive line and character decoder
  // ****************************************
  logic s1;
  logic s2;
  logic s3;
  logic rxLvl;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      rxLvl <= 1'b1;
    end else begin
      s1 <= rxPin;
      s2 <= s1;
      s3 <= s2;
      rxLvl <= (s2 == s3) ? s3 : rxLvl;
    end
  end

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000
  } spp_rx_t;
  spp_rx_t rxState;
  logic [spp_pkg::DIV_W-1:0] rxCnt;
  logic [3:0] rxBit;
  logic [8:0] rxShift;
  logic rxDone;
  wire parEn = cfg.parity != spp_pkg::PAR_NONE;
  wire [3:0] rxBits = spp_pkg::DATA_BITS + {3'h0, parEn};
  wire rxTick = rxCnt == '0;
  wire [7:0] rxByte = parEn ? rxShift[7:0] : rxShift[8:1];
  // parity check, odd parity wants an odd sum
  wire parBad = parEn && ((^rxShift) != (cfg.parity == spp_pkg::PAR_ODD));

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rxState <= RX_IDLE;
      rxCnt <= '0;
      rxBit <= '0;
      rxShift <= '0;
      rxDone <= 1'b0;
    end else begin
      rxDone <= 1'b0;
      rxCnt <= rxTick ? '0 : rxCnt - 1'b1;
      case (rxState)
        RX_IDLE: if (!rxLvl) begin
          rxState <= RX_START;
          rxCnt <= cfg.div >> 1;
        end
        RX_START: if (rxTick) begin
          rxState <= rxLvl ? RX_IDLE : RX_DATA;
          rxCnt <= cfg.div - 1'b1;
          rxBit <= '0;
        end
        RX_DATA: if (rxTick) begin
          rxShift <= {rxLvl, rxShift[8:1]};
          rxBit <= rxBit + 1'b1;
          rxCnt <= cfg.div - 1'b1;
          if (rxBit == rxBits - 1'b1) rxState <= RX_STOP;
        end
        RX_STOP: if (rxTick) begin
          rxState <= RX_IDLE;
          rxDone <= 1'b1;
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end

  // ****************************************
  // Receive buffer and flow control
  // ****************************************
  logic inReady;
  logic outValid;
  logic [7:0] outData;
  logic [spp_pkg::LVL_W-1:0] pendCount;
  logic [spp_pkg::LVL_W-1:0] relRemain;
  wire push = rxDone && inReady;
  wire relOpen = relRemain != '0;

  spp_fifo #(.WIDTH(spp_pkg::FIFO_W), .DEPTH(spp_pkg::FIFO_DEPTH)) buffer (
    .clock(clock),
    .nrst(nrst),
    .inValid(rxDone),
    .inReady(inReady),
    .inData(rxByte),
    .outValid(outValid),
    .outReady(pktReady && relOpen),
    .outData(outData),
    .level(level)
  );

  // A full buffer also holds CTS off, since the threshold may exceed the depth
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctsN <= 1'b0;
    end else begin
      ctsN <= ({6'h0, level} >= cfg.hold) || !inReady;
    end
  end

  // Sticky error flags; a new event wins over the clearing read
  wire stRead = cfgRead && cfgSel == spp_pkg::SEL_STATUS;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ovfFlag <= 1'b0;
      parErrFlag <= 1'b0;
      frmErrFlag <= 1'b0;
    end else begin
      ovfFlag <= (rxDone && !inReady) || (ovfFlag && !stRead);
      parErrFlag <= (rxDone && parBad) || (parErrFlag && !stRead);
      frmErrFlag <= (rxDone && !rxLvl) || (frmErrFlag && !stRead);
    end
  end

  // ****************************************
  // Packet release
  // ****************************************
  logic [31:0] idleCnt;
  wire [3:0] charBits = 4'h2 + rxBits + {3'h0, cfg.stop};
  wire [31:0] charCyc = 32'(cfg.div) * 32'(charBits);
  wire [31:0] gapCyc = 32'(cfg.gap) * charCyc;
  wire [31:0] idleNeed = (gapCyc < SIL) ? gapCyc : SIL;
  wire pending = pendCount != '0;
  wire trigGap0 = cfg.gap == 8'h0;
  wire trigIdle = idleCnt >= idleNeed;
  wire trigFull = pendCount == spp_pkg::MAX_PKT;
  wire trig = pending && (trigGap0 || trigIdle || trigFull);
  wire pop = outValid && pktReady && relOpen;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      idleCnt <= '0;
    end else if (rxState != RX_IDLE || !rxLvl) begin
      idleCnt <= '0;
    end else if (idleCnt < SIL) begin
      idleCnt <= idleCnt + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pendCount <= '0;
      relRemain <= '0;
    end else if (!relOpen && trig) begin
      pendCount <= {5'h0, push};
      relRemain <= pendCount;
    end else begin
      pendCount <= pendCount + {5'h0, push};
      relRemain <= relRemain - {5'h0, pop};
    end
  end

  assign pktValid = outValid && relOpen;
  assign pkt.data = outData;
  assign pkt.last = relRemain == 6'h1;

  // ****************************************
  // Service port to serial transmit
  // ****************************************
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} spp_tx_t;
  spp_tx_t txState;
  logic [11:0] txShift;
  logic [3:0] txLeft;
  logic [spp_pkg::DIV_W-1:0] txCnt;
  // only the enabled service port is forwarded
  wire svcHit = cfg.port != spp_pkg::PORT_OFF && net.port == cfg.port;
  wire txIdle = txState == TX_IDLE;
  assign netReady = !svcHit || txIdle;
  wire txPar = (^net.data) ^ (cfg.parity == spp_pkg::PAR_ODD);
  wire [11:0] txFrame = {2'h3, parEn ? txPar : 1'b1, net.data, 1'b0};

  always_ff @(posedge clock) begin
    if (!nrst) begin
      txState <= TX_IDLE;
      txShift <= 12'hfff;
      txLeft <= '0;
      txCnt <= '0;
      txPin <= 1'b1;
    end else begin
      case (txState)
        TX_IDLE: if (netValid && svcHit) begin
          txState <= TX_SHIFT;
          txShift <= txFrame;
          txLeft <= charBits;
          txCnt <= '0;
        end
        TX_SHIFT: begin
          txCnt <= (txCnt == '0) ? cfg.div - 1'b1 : txCnt - 1'b1;
          if (txCnt == '0) begin
            txPin <= txShift[0];
            txShift <= {1'b1, txShift[11:1]};
            txLeft <= txLeft - 1'b1;
            if (txLeft == 4'h0) txState <= TX_IDLE;
          end
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_codeRate;
    @(posedge clock) disable iff (!nrst)
    cfgWrite && cfgSel == spp_pkg::SEL_RATE && wd == 32'h7 |=> cfg.rate == 32'h7;
  endproperty
  a_codeRate: assert property (p_codeRate) else $error("rate code not taken");

  property p_badRate;
    @(posedge clock) disable iff (!nrst)
    cfgWrite && cfgSel == spp_pkg::SEL_RATE && wd > 32'ha && wd < spp_pkg::RATE_LIT_MIN
    |=> $stable(cfg.div) && $stable(cfg.rate);
  endproperty
  a_badRate: assert property (p_badRate) else $error("out of range rate stored");

  property p_parity;
    @(posedge clock) disable iff (!nrst)
    cfgWrite && cfgSel == spp_pkg::SEL_PARITY && wd > 32'h2 |=> $stable(cfg.parity);
  endproperty
  a_parity: assert property (p_parity) else $error("bad parity stored");

  property p_hold;
    @(posedge clock) disable iff (!nrst)
    cfgWrite && cfgSel == spp_pkg::SEL_HOLD && wd < 32'h11 |=> $stable(cfg.hold);
  endproperty
  a_hold: assert property (p_hold) else $error("bad threshold stored");

  property p_cts;
    @(posedge clock) disable iff (!nrst)
    {6'h0, level} >= cfg.hold |=> ctsN;
  endproperty
  a_cts: assert property (p_cts) else $error("CTS not deasserted");

  property p_gapZero;
    @(posedge clock) disable iff (!nrst)
    trigGap0 && pending && !relOpen |=> relRemain == $past(pendCount);
  endproperty
  a_gapZero: assert property (p_gapZero) else $error("char not forwarded");

  property p_full;
    @(posedge clock) disable iff (!nrst)
    pendCount == spp_pkg::MAX_PKT && !relOpen |=> relRemain == spp_pkg::MAX_PKT;
  endproperty
  a_full: assert property (p_full) else $error("full packet not sent");

  property p_silence;
    @(posedge clock) disable iff (!nrst)
    idleCnt >= SIL && pending && !relOpen |=> relOpen;
  endproperty
  a_silence: assert property (p_silence) else $error("silence did not send");

  property p_svcOff;
    @(posedge clock) disable iff (!nrst)
    txIdle && netValid && cfg.port == spp_pkg::PORT_OFF |-> netReady ##1 txIdle;
  endproperty
  a_svcOff: assert property (p_svcOff) else $error("disabled port forwarded");

endmodule // spp_serial_packetizer

// ==== common/spp_pkg.sv ====
// Shared constants, types and rate arithmetic for the serial packetizer
package spp_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int SILENCE_NS = 100_000;
  // Least time, rounded up to whole cycles
  localparam int SILENCE_CYC = (SILENCE_NS * CLK_MHZ + 999) / 1000;

  // ****************************************
  // Widths and sizes
  // ****************************************
  localparam int DIV_W = 24;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W = 8;
  localparam int LVL_W = 6;
  localparam logic [LVL_W-1:0] MAX_PKT = 6'h20;
  localparam logic [3:0] DATA_BITS = 4'h8;

  // ****************************************
  // Setting ranges and reset values
  // ****************************************
  localparam logic [31:0] RATE_CODE_MIN = 32'h1;
  localparam logic [31:0] RATE_CODE_MAX = 32'ha;
  localparam logic [31:0] RATE_LIT_MIN = 32'h5b9;
  localparam logic [31:0] RATE_LIT_MAX = 32'h5b8d80;
  localparam logic [31:0] RATE_RST = 32'h3;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [7:0] GAP_RST = 8'h3;
  localparam logic [11:0] HOLD_MIN = 12'h11;
  localparam logic [11:0] HOLD_MAX = 12'h823;
  localparam logic [11:0] HOLD_RST = 12'h7f3;
  localparam logic [1:0] MODE_TRANSPARENT = 2'h0;
  localparam logic [1:0] MODE_FRAMED = 2'h1;
  localparam logic [1:0] MODE_ESCAPED = 2'h2;
  localparam logic [1:0] FMT_MAX = 2'h2;
  localparam logic [1:0] FMT_RST = 2'h2;
  localparam logic [15:0] PORT_RST = 16'h2616;
  localparam logic [15:0] PORT_OFF = 16'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    SEL_RATE = 4'h0, SEL_PARITY = 4'h1, SEL_STOP = 4'h2, SEL_GAP = 4'h3,
    SEL_HOLD = 4'h4, SEL_MODE = 4'h5, SEL_FORMAT = 4'h6, SEL_PORT = 4'h7,
    SEL_STATUS = 4'h8
  } spp_sel_t;

  typedef struct packed {
    logic [31:0] rate;
    logic [DIV_W-1:0] div;
    logic [1:0] parity;
    logic stop;
    logic [7:0] gap;
    logic [11:0] hold;
    logic [1:0] mode;
    logic [1:0] format;
    logic [15:0] port;
  } spp_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } spp_pkt_t;

  typedef struct packed {
    logic [15:0] port;
    logic [7:0] data;
  } spp_net_t;

  // Nearest whole divisor for a bit rate
  function automatic logic [31:0] rate_div(input logic [31:0] r);
    rate_div = (CLK_HZ + (r >> 1)) / r;
  endfunction

  function automatic logic [31:0] code_rate(input logic [3:0] c);
    case (c)
      4'h1: code_rate = 32'd2400;
      4'h2: code_rate = 32'd4800;
      4'h3: code_rate = 32'd9600;
      4'h4: code_rate = 32'd19200;
      4'h5: code_rate = 32'd38400;
      4'h6: code_rate = 32'd57600;
      4'h7: code_rate = 32'd115200;
      4'h8: code_rate = 32'd230400;
      4'h9: code_rate = 32'd460800;
      default: code_rate = 32'd921600;
    endcase
  endfunction

endpackage

// ==== rtl/spp_ram.sv ====
// Simple dual-port byte store with registered read data
`timescale 1ns/1ps
module spp_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clock,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule // spp_ram

// ==== rtl/spp_fifo.sv ====
// First-word-fall-through FIFO over the byte store
`timescale 1ns/1ps
module spp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [AW:0] level
);

  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic wroteHead;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  wire [AW-1:0] rdAddr = pop ? AW'(rdPtr + 1'b1) : rdPtr;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  localparam logic [AW:0] ONE = (AW + 1)'(1);

  assign inReady = level != FULL;
  // The store reads one cycle late, so a word written into the head slot waits a cycle
  assign outValid = (level > ONE) || (level == ONE && !wroteHead);

  spp_ram #(.WIDTH(WIDTH), .DEPTH(DEPTH)) ram (
    .clock(clock),
    .wrEn(push),
    .wrAddr(wrPtr),
    .wrData(inData),
    .rdAddr(rdAddr),
    .rdData(outData)
  );

  always_ff @(posedge clock) begin
    if (!nrst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      level <= '0;
      wroteHead <= 1'b0;
    end else begin
      wrPtr <= push ? AW'(wrPtr + 1'b1) : wrPtr;
      rdPtr <= rdAddr;
      level <= (AW + 1)'(level + push - pop);
      wroteHead <= push && (wrPtr == rdAddr);
    end
  end

endmodule // spp_fifo

// ==== sim/spp_host_model.sv ====
// Host side of the serial link: paced byte sender and frame catcher
`timescale 1ns/1ps
module spp_host_model (
  input wire logic clock,
  output logic rxPin,
  input wire logic txPin,
  input wire logic ctsN,
  input wire logic [31:0] div,
  input wire logic [1:0] par,
  input wire logic stop
);
  logic [7:0] caught[$];

  initial begin
    rxPin = 1'b1;
  end

  task automatic bit_out(input logic b);
    rxPin <= b;
    repeat (div) @(posedge clock);
  endtask

  // ****************************************
  // Sender
  // ****************************************
  // wait for clear-to-send
  task automatic send(input logic [7:0] d, input logic badPar);
    logic p;
    p = (^d) ^ (par == 2'h2) ^ badPar;
    while (ctsN !== 1'b0) @(posedge clock);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(d[i]);
    if (par != 2'h0) bit_out(p);
    bit_out(1'b1);
    if (stop) bit_out(1'b1);
  endtask

  // ****************************************
  // Catcher, samples mid-bit
  // ****************************************
  always begin
    logic [7:0] d;
    @(negedge txPin);
    repeat (div / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(posedge clock);
      d[i] = txPin;
    end
    repeat (div * (1 + (par != 2'h0))) @(posedge clock);
    caught.push_back(d);
  end
endmodule // spp_host_model

// ==== sim/tb_top.sv ====
// Self-checking bench for the serial packetizer
`timescale 1ns/1ps
module tb_top;
  localparam int SIL = 2000;
  logic clock, nrst, cfgWrite, cfgRead, pktReady, netValid, rxPin, txPin, ctsN;
  logic pktValid, netReady, stop;
  logic [1:0] par;
  logic [31:0] cfgWData, cfgRData, v;
  spp_pkg::spp_sel_t cfgSel;
  spp_pkg::spp_cfg_t cfg;
  spp_pkg::spp_pkt_t pkt;
  spp_pkg::spp_net_t net;
  int div, bad_count, cmp_count;
  logic [8:0] got[$];
  logic [7:0] sent[$];
  int rates[10] = '{2400, 4800, 9600, 19200, 38400, 57600, 115200, 230400, 460800, 921600};
  int ts[18] = '{1, 1, 2, 2, 3, 3, 4, 4, 4, 4, 5, 5, 5, 6, 6, 6, 7, 7};
  logic [31:0] tw[18] = '{2, 3, 1, 2, 32'hff, 32'h100, 32'h10, 32'h11, 32'h824, 32'h823,
    1, 2, 3, 0, 1, 3, 32'h10000, 32'h1234};
  logic [31:0] te[18] = '{2, 2, 1, 1, 32'hff, 32'hff, 32'h7f3, 32'h11, 32'h11, 32'h823,
    1, 2, 2, 0, 1, 1, 32'h2616, 32'h1234};
  int lw[5] = '{32'hf4240, 32'h5b8, 32'h5b8d81, 32'h5b9, 32'h2dc6c0};
  int le[5] = '{32'hf4240, 32'hf4240, 32'hf4240, 32'h5b9, 32'h2d69be};

  spp_serial_packetizer #(.SILENCE_CYC(SIL)) u_spp_serial_packetizer (.clock(clock),
    .nrst(nrst), .rxPin(rxPin), .txPin(txPin), .ctsN(ctsN), .cfgWrite(cfgWrite),
    .cfgRead(cfgRead), .cfgSel(cfgSel), .cfgWData(cfgWData), .cfgRData(cfgRData), .cfg(cfg),
    .pktValid(pktValid), .pktReady(pktReady), .pkt(pkt), .netValid(netValid),
    .netReady(netReady), .net(net));
  spp_host_model u_spp_host_model (.clock(clock), .rxPin(rxPin), .txPin(txPin), .ctsN(ctsN),
    .div(div), .par(par), .stop(stop));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock) if (pktValid === 1'b1 && pktReady) got.push_back({pkt.last, pkt.data});

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input int s, input logic [31:0] d);
    @(posedge clock);
    cfgWrite <= 1'b1;
    cfgSel <= spp_pkg::spp_sel_t'(s);
    cfgWData <= d;
    @(posedge clock);
    cfgWrite <= 1'b0;
  endtask
  // Waits one extra edge so either load timing of the read word is covered
  task automatic rd(input int s);
    @(posedge clock);
    cfgRead <= 1'b1;
    cfgSel <= spp_pkg::spp_sel_t'(s);
    @(posedge clock);
    cfgRead <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    v = cfgRData;
  endtask
  task automatic rc(input string n, input int s, input logic [31:0] e);
    rd(s);
    chk(n, v, e);
  endtask
  task automatic sendn(input int n, input logic [7:0] base);
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      d = base + 8'(i * 3);
      sent.push_back(d);
      u_spp_host_model.send(d, 1'b0);
    end
  endtask
  task automatic waitn(input int n, input int lim);
    for (int i = 0; i < lim && got.size() < n; i++) @(posedge clock);
  endtask
  task automatic chk_pkts(input int len);
    chk("packet bytes", got.size(), sent.size());
    foreach (sent[i]) chk("packet byte", got[i], {((i + 1) % len == 0), sent[i]});
    got.delete();
    sent.delete();
  endtask
  task automatic net_send(input logic [15:0] p, input logic [7:0] d);
    @(posedge clock);
    netValid <= 1'b1;
    net <= '{port: p, data: d};
    @(negedge clock);
    while (netReady !== 1'b1) @(negedge clock);
    @(posedge clock);
    netValid <= 1'b0;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    nrst = 1'b0;
    cfgWrite = 1'b0;
    cfgRead = 1'b0;
    cfgSel = spp_pkg::SEL_RATE;
    cfgWData = 32'h0;
    pktReady = 1'b0;
    netValid = 1'b0;
    net = '0;
    par = 2'h0;
    stop = 1'b0;
    div = 13021;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    rc("rate", 0, 32'h3);
    rc("parity", 1, 32'h0);
    rc("stop", 2, 32'h0);
    rc("gap", 3, 32'h3);
    rc("hold", 4, 32'h7f3);
    rc("mode", 5, 32'h0);
    rc("format", 6, 32'h2);
    rc("port", 7, 32'h2616);
    $display("test reset values done");
    for (int c = 1; c <= 10; c++) begin
      wr(0, c);
      rc("rate code", 0, c);
      chk("divisor", cfg.div, (125000000 + rates[c-1] / 2) / rates[c-1]);
    end
    for (int i = 0; i < 5; i++) begin
      wr(0, lw[i]);
      rc("literal rate", 0, le[i]);
    end
    div = 42;
    $display("test rates done");
    for (int i = 0; i < 18; i++) begin
      wr(ts[i], tw[i]);
      rc("setting", ts[i], te[i]);
    end
    wr(1, 0);
    wr(2, 0);
    $display("test setting ranges done");
    pktReady <= 1'b1;
    wr(3, 1);
    sendn(3, 8'h10);
    waitn(3, 1000);
    chk_pkts(3);
    wr(3, 0);
    sendn(2, 8'h40);
    waitn(2, 50);
    chk_pkts(1);
    wr(3, 32'hff);
    sendn(2, 8'h60);
    waitn(2, SIL + 300);
    chk_pkts(2);
    sendn(32, 8'h80);
    waitn(32, 100);
    chk_pkts(32);
    $display("test packetizing done");
    pktReady <= 1'b0;
    wr(4, 32'h11);
    sendn(16, 8'h01);
    repeat (5) @(posedge clock);
    chk("cts below level", ctsN, 1'b0);
    sendn(1, 8'hc0);
    repeat (5) @(posedge clock);
    chk("cts at level", ctsN, 1'b1);
    pktReady <= 1'b1;
    waitn(17, SIL + 300);
    chk_pkts(17);
    $display("test flow control done");
    wr(1, 1);
    wr(2, 1);
    par = 2'h1;
    stop = 1'b1;
    rd(8);
    u_spp_host_model.send(8'h5a, 1'b0);
    // One byte still buffered, no flags raised
    rc("even parity flag", 8, 32'h20);
    u_spp_host_model.send(8'h5a, 1'b1);
    rd(8);
    chk("bad parity flag", v[3], 1'b1);
    wr(1, 2);
    par = 2'h2;
    u_spp_host_model.send(8'h33, 1'b0);
    rd(8);
    chk("odd parity flag", v[3], 1'b0);
    waitn(3, SIL + 300);
    got.delete();
    $display("test parity done");
    net_send(16'h1234, 8'ha5);
    @(negedge clock);
    chk("ready while sending", netReady, 1'b0);
    net_send(16'h1111, 8'h3c);
    repeat (800) @(posedge clock);
    chk("tx frames", u_spp_host_model.caught.size(), 1);
    chk("tx byte", u_spp_host_model.caught[0], 8'ha5);
    wr(7, 0);
    net_send(16'h0000, 8'h77);
    repeat (800) @(posedge clock);
    chk("tx when off", u_spp_host_model.caught.size(), 1);
    $display("test service port done");
    end_sim();
  end

  initial begin
    #400000;
    bad_count++;
    $display("watchdog expired");
    end_sim();
  end
endmodule // tb_top
